// [hdl/sopc_map.svh]
`ifndef SOPC_MAP_SVH
`define SOPC_MAP_SVH

`define SOPC_OFF_DATA_LO 12'h000
`define SOPC_OFF_DATA_HI 12'h004
`define SOPC_OFF_CMD 12'h008
`define SOPC_OFF_STATUS 12'h00C
`define SOPC_OFF_RES_LO 12'h010
`define SOPC_OFF_RES_HI 12'h014

`define SOPC_CMD_LSB 0
`define SOPC_CMD_MSB 9
`define SOPC_ST_BUSY 0
`define SOPC_ST_ERR 1
`define SOPC_ST_UTC 2
`define SOPC_ST_PEND_LSB 3
`define SOPC_ST_EN_LSB 6

`define SOPC_FMIN 36'h0_0000_0001
`define SOPC_FMAX_SINE 36'h7_0219_8D00
`define SOPC_FMAX_AUX 36'h0_3B9A_CA00
`define SOPC_FMAX_AUX_SIN 36'h2_540B_E400
`define SOPC_FMAX_PULSE 36'h5_D21D_BA00
`define SOPC_FDEF_BASE 36'h0_3B9A_CA00
`define SOPC_FDEF_PULSE 36'h0_0000_03E8

`define SOPC_FULL_TURN 32'h0005_7E40
`define SOPC_DELAY_MAX 32'h3B9A_CA00
`define SOPC_RAD2MDEG 16'h0EAB
`define SOPC_MDEG2URAD 21'h11_7416
`define SOPC_NS2MDEG 20'h6_0A30
`define SOPC_MDEG2NS_NUM 22'h2A_62B2

`define SOPC_SEC_S 1
`define SOPC_NS_PER_S 1000000000
`define SOPC_CLK_NS 10

`endif

// [hdl/sopc_pkg.sv]
`default_nettype none
package sopc_pkg;

    typedef enum logic [3:0] {
        op_nop, op_set_freq, op_get_freq, op_set_func, op_get_cfg, op_set_phase,
        op_get_phase, op_phase_ref, op_sync, op_set_auto, op_set_delay, op_get_delay,
        op_set_unit, op_set_pview, op_cmd_reset
    } sopc_op_t;

    typedef enum logic [2:0] {
        aux_sinusoid, aux_triangle, aux_square, hundred_megahertz_sine, aux_irig
    } sopc_aux_fn_t;

    typedef enum logic [2:0] {pulse_plain, pulse_irig} sopc_pulse_fn_t;
    typedef enum logic [1:0] {unit_deg, unit_rad, unit_sec, unit_default} sopc_unit_t;
    typedef enum logic [1:0] {lim_value, lim_min, lim_max} sopc_lim_t;
    typedef enum logic [1:0] {st_idle, st_exec, st_div} sopc_state_t;

    typedef struct packed {
        sopc_lim_t lim;
        sopc_unit_t unit;
        logic [1:0] sfx;
        sopc_op_t op;
    } sopc_cmd_t;

    typedef struct packed {
        logic enable;
        logic align;
        logic [2:0] func;
        logic pview;
        logic [35:0] freq_mhz;
        logic [31:0] phase_mdeg;
        logic [31:0] delay_ns;
    } sopc_src_t;

endpackage
`default_nettype wire

// [hdl/sopc_div.sv]
`default_nettype none
module sopc_div #(
    parameter int W = 40
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [W-1:0] dividend_i,
    input wire logic [W-1:0] divisor_i,
    output logic [W-1:0] quot_o,
    output logic done_o
);
    logic [W-1:0] rem_reg;
    logic [W-1:0] dvs_reg;
    logic [7:0] cnt_reg;
    wire [W:0] cand = {rem_reg, quot_o[W-1]};
    wire ge = cand >= {1'b0, dvs_reg};
    wire [W:0] diff = cand - {1'b0, dvs_reg};

    // Restoring division, one quotient bit per cycle, to keep the datapath narrow.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rem_reg <= '0;
            dvs_reg <= '0;
            quot_o <= '0;
            cnt_reg <= 8'h00;
            done_o <= 1'b0;
        end else if (start_i) begin
            rem_reg <= '0;
            dvs_reg <= divisor_i;
            quot_o <= dividend_i;
            cnt_reg <= 8'(W);
            done_o <= 1'b0;
        end else begin
            done_o <= cnt_reg == 8'h01;
            if (cnt_reg != 8'h00) begin
                rem_reg <= ge ? diff[W-1:0] : cand[W-1:0];
                quot_o <= {quot_o[W-2:0], ge};
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [hdl/sopc_top.sv]
// Decided for this implementation: the register addresses and the APB interface to the registers.
`include "sopc_map.svh"
`default_nettype none
module sopc_top
    import sopc_pkg::*;
#(
    parameter int CYC_PER_SEC = `SOPC_SEC_S * `SOPC_NS_PER_S / `SOPC_CLK_NS
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic utc_pps_i,
    input wire logic utc_valid_i,
    input wire logic [2:0] nvm_auto_i,
    input wire logic [31:0] nvm_delay_i [3],
    output logic nvm_wr_o,
    output logic [2:0] nvm_auto_o,
    output logic [31:0] nvm_delay_o [3],
    output sopc_src_t src_o [3]
);
    sopc_state_t state_reg;
    sopc_cmd_t cmd_reg;
    logic [39:0] data_reg;
    logic [39:0] res_reg;
    logic err_reg;
    logic nvm_pend_reg;
    logic [2:0] pps_sync_reg;
    logic [1:0] valid_sync_reg;
    logic [31:0] sec_cnt_reg;

    logic [35:0] freq_reg [3];
    logic [2:0] func_reg [3];
    logic pview_reg [3];
    sopc_unit_t unit_reg [3];
    logic [31:0] phase_reg [3];
    logic [31:0] ref_reg [3];
    logic auto_reg [3];
    logic [31:0] delay_reg [3];
    logic pend_reg [3];

    // Second boundary: UTC pulse when UTC is known, else the internal second, whose count each UTC pulse restarts.
    wire pps_rise = pps_sync_reg[1] & ~pps_sync_reg[2];
    wire int_tick = sec_cnt_reg == 32'(CYC_PER_SEC - 1);
    wire sec_tick = valid_sync_reg[1] ? pps_rise : int_tick;

    wire apb_acc = psel_i & penable_i;
    wire apb_take = apb_acc & pready_o;
    wire hit_dlo = paddr_i == `SOPC_OFF_DATA_LO;
    wire hit_dhi = paddr_i == `SOPC_OFF_DATA_HI;
    wire hit_cmd = paddr_i == `SOPC_OFF_CMD;
    wire hit_st = paddr_i == `SOPC_OFF_STATUS;
    wire hit_rlo = paddr_i == `SOPC_OFF_RES_LO;
    wire hit_rhi = paddr_i == `SOPC_OFF_RES_HI;
    wire mapped = hit_dlo | hit_dhi | hit_cmd | hit_st | hit_rlo | hit_rhi;
    wire busy = state_reg != st_idle;
    wire cmd_wr = apb_take & pwrite_i & hit_cmd;
    wire cmd_start = cmd_wr & ~busy;

    logic [31:0] status_w;
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`SOPC_ST_BUSY] = busy;
        status_w[`SOPC_ST_ERR] = err_reg;
        status_w[`SOPC_ST_UTC] = valid_sync_reg[1];
        for (int k = 0; k < 3; k++) begin
            status_w[`SOPC_ST_PEND_LSB + k] = pend_reg[k];
            status_w[`SOPC_ST_EN_LSB + k] = src_o[k].enable;
        end
    end

    wire [31:0] rdata_w = hit_dlo ? data_reg[31:0] :
                          hit_dhi ? {24'h00_0000, data_reg[39:32]} :
                          hit_cmd ? {22'h00_0000, cmd_reg} :
                          hit_st ? status_w :
                          hit_rlo ? res_reg[31:0] :
                          hit_rhi ? {24'h00_0000, res_reg[39:32]} : 32'h0000_0000;

    // Command decode, valid during the single execute cycle.
    wire exec = state_reg == st_exec;
    wire [1:0] idx_w = (cmd_reg.sfx == 2'h0) ? 2'h0 : cmd_reg.sfx - 2'h1;
    wire [35:0] cur_freq = freq_reg[idx_w];
    wire [2:0] cur_func = func_reg[idx_w];
    wire [31:0] cur_phase = phase_reg[idx_w];

    function automatic logic [35:0] fmax_of(input logic [1:0] ch, input logic [2:0] fn);
        if (ch == 2'h0) begin
            return `SOPC_FMAX_SINE;
        end
        if (ch == 2'h2) begin
            return `SOPC_FMAX_PULSE;
        end
        return (fn == 3'(aux_sinusoid)) ? `SOPC_FMAX_AUX_SIN : `SOPC_FMAX_AUX;
    endfunction

    wire [35:0] fmax_cur = fmax_of(idx_w, cur_func);
    wire [35:0] fset_w = (cmd_reg.lim == lim_min) ? `SOPC_FMIN :
                         (cmd_reg.lim == lim_max) ? fmax_cur : data_reg[35:0];
    wire fset_ok = (fset_w >= `SOPC_FMIN) && (fset_w <= fmax_cur);

    // A waveform change that would leave the present frequency above the new ceiling is refused.
    wire [2:0] fn_new = data_reg[2:0];
    wire fn_aux_ok = (fn_new <= 3'(aux_irig)) && (cur_freq <= fmax_of(2'h1, fn_new));
    wire fn_pls_ok = fn_new <= 3'(pulse_irig);
    wire fn_ok = (idx_w == 2'h1) ? fn_aux_ok : (idx_w == 2'h2) & fn_pls_ok;

    sopc_unit_t unit_eff;
    assign unit_eff = (cmd_reg.unit == unit_default) ? unit_reg[idx_w] : cmd_reg.unit;

    // Phase is held in millidegrees; radians arrive in microradians, seconds in nanoseconds.
    wire signed [47:0] data_s = $signed({{16{data_reg[31]}}, data_reg[31:0]});
    wire signed [63:0] rad_prod = data_s * $signed({48'h0000_0000_0000, `SOPC_RAD2MDEG});
    wire signed [95:0] sec_prod = data_s * $signed({60'h0, cur_freq})
                                  * $signed({76'h0, `SOPC_NS2MDEG});
    logic signed [47:0] ph_in;
    assign ph_in = (unit_eff == unit_rad) ? rad_prod[63:16] :
                   (unit_eff == unit_sec) ? sec_prod[87:40] : data_s;
    wire signed [47:0] full_s = $signed({16'h0000, `SOPC_FULL_TURN});
    wire signed [47:0] ph_delta = ph_in - $signed({16'h0000, cur_phase});
    wire ph_ok = (ph_delta <= full_s) && (ph_delta >= -full_s);
    logic signed [47:0] ph_wrap;
    assign ph_wrap = (ph_in < 0) ? ph_in + full_s :
                     (ph_in >= full_s) ? ph_in - full_s : ph_in;

    wire [63:0] urad_prod = {32'h0000_0000, cur_phase} * {43'h0, `SOPC_MDEG2URAD};
    wire [39:0] div_num = {8'h00, cur_phase} * {18'h0_0000, `SOPC_MDEG2NS_NUM};
    wire [39:0] div_quot;
    wire div_done;
    wire div_start = exec & (cmd_reg.op == op_get_phase) & (unit_eff == unit_sec);

    sopc_div #(
        .W(40)
    ) u_div (
        .clk_i(ref_clk_i),
        .rst_i(sys_rst_i),
        .start_i(div_start),
        .dividend_i(div_num),
        .divisor_i({4'h0, cur_freq}),
        .quot_o(div_quot),
        .done_o(div_done)
    );

    wire signed [31:0] dly_lim = $signed(`SOPC_DELAY_MAX);
    logic signed [31:0] dly_set;
    assign dly_set = (cmd_reg.lim == lim_min) ? -dly_lim :
                     (cmd_reg.lim == lim_max) ? dly_lim : $signed(data_reg[31:0]);
    wire dly_ok = (dly_set <= dly_lim) && (dly_set >= -dly_lim);

    logic acc_w;
    always_comb begin
        case (cmd_reg.op)
            op_set_freq: acc_w = fset_ok;
            op_set_func: acc_w = fn_ok;
            op_set_phase: acc_w = ph_ok;
            op_set_delay: acc_w = dly_ok;
            op_set_unit: acc_w = cmd_reg.unit != unit_default;
            op_set_pview: acc_w = (idx_w == 2'h2) & (cur_func == 3'(pulse_plain));
            default: acc_w = 1'b1;
        endcase
    end

    wire do_w = exec & acc_w;
    wire rst_all = do_w & (cmd_reg.op == op_cmd_reset);
    wire [39:0] freq_res = (cmd_reg.lim == lim_min) ? {4'h0, `SOPC_FMIN} :
                           (cmd_reg.lim == lim_max) ? {4'h0, fmax_cur} :
                           {4'h0, cur_freq};
    wire [39:0] ph_res = (unit_eff == unit_rad) ? {8'h00, urad_prod[47:16]} :
                         {8'h00, cur_phase};
    wire [39:0] cfg_res = {33'h0_0000_0000, auto_reg[idx_w], pview_reg[idx_w],
                           unit_reg[idx_w], cur_func};
    wire [39:0] dly_res = {{8{delay_reg[idx_w][31]}}, delay_reg[idx_w]};
    wire [39:0] res_w = (cmd_reg.op == op_get_freq) ? freq_res :
                        (cmd_reg.op == op_get_phase) ? ph_res :
                        (cmd_reg.op == op_get_cfg) ? cfg_res :
                        (cmd_reg.op == op_get_delay) ? dly_res : res_reg;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= apb_acc & ~pready_o;
            prdata_o <= (apb_acc & ~pready_o & ~pwrite_i) ? rdata_w : 32'h0000_0000;
            pslverr_o <= apb_acc & ~pready_o & ~mapped;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pps_sync_reg <= 3'h0;
            valid_sync_reg <= 2'h0;
            sec_cnt_reg <= 32'h0000_0000;
        end else begin
            pps_sync_reg <= {pps_sync_reg[1:0], utc_pps_i};
            valid_sync_reg <= {valid_sync_reg[0], utc_valid_i};
            sec_cnt_reg <= (int_tick | pps_rise) ? 32'h0000_0000 : sec_cnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= st_idle;
            cmd_reg <= '0;
            data_reg <= 40'h00_0000_0000;
            res_reg <= 40'h00_0000_0000;
            err_reg <= 1'b0;
            nvm_pend_reg <= 1'b0;
            nvm_wr_o <= 1'b0;
            nvm_auto_o <= 3'h0;
        end else begin
            if (apb_take & pwrite_i & hit_dlo) begin
                data_reg[31:0] <= pwdata_i;
            end
            if (apb_take & pwrite_i & hit_dhi) begin
                data_reg[39:32] <= pwdata_i[7:0];
            end
            nvm_pend_reg <= do_w & ((cmd_reg.op == op_set_auto) | (cmd_reg.op == op_set_delay));
            nvm_wr_o <= nvm_pend_reg;
            nvm_auto_o <= {auto_reg[2], auto_reg[1], auto_reg[0]};
            case (state_reg)
                st_idle: begin
                    if (cmd_start) begin
                        cmd_reg <= sopc_cmd_t'(pwdata_i[`SOPC_CMD_MSB:`SOPC_CMD_LSB]);
                        err_reg <= 1'b0;
                        state_reg <= st_exec;
                    end
                end
                st_exec: begin
                    err_reg <= ~acc_w;
                    res_reg <= res_w;
                    state_reg <= div_start ? st_div : st_idle;
                end
                st_div: begin
                    if (div_done) begin
                        res_reg <= div_quot;
                        state_reg <= st_idle;
                    end
                end
                default: state_reg <= st_idle;
            endcase
            if (cmd_wr & busy) begin
                err_reg <= 1'b1;
            end
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_ch
        localparam logic [35:0] FDEF = (i == 2) ? `SOPC_FDEF_PULSE : `SOPC_FDEF_BASE;
        wire sel = do_w & (idx_w == 2'(i));
        wire op_sync_w = sel & (cmd_reg.op == op_sync);
        wire go_sync = op_sync_w | (sel & (cmd_reg.op == op_set_freq) & auto_reg[i]);
        wire align_now = pend_reg[i] & sec_tick & ~go_sync;
        wire [32:0] out_sum = {1'b0, ref_reg[i]} + {1'b0, phase_reg[i]};
        wire [32:0] out_wrap = (out_sum >= {1'b0, `SOPC_FULL_TURN}) ?
                               out_sum - {1'b0, `SOPC_FULL_TURN} : out_sum;

        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                auto_reg[i] <= nvm_auto_i[i];
                delay_reg[i] <= nvm_delay_i[i];
                pend_reg[i] <= 1'b0;
                nvm_delay_o[i] <= 32'h0000_0000;
            end else begin
                if (sel & (cmd_reg.op == op_set_auto)) begin
                    auto_reg[i] <= data_reg[0];
                end
                if (sel & (cmd_reg.op == op_set_delay)) begin
                    delay_reg[i] <= dly_set;
                end
                // A new request in the boundary cycle keeps the request pending.
                if (go_sync) begin
                    pend_reg[i] <= 1'b1;
                end else if (sec_tick) begin
                    pend_reg[i] <= 1'b0;
                end
                nvm_delay_o[i] <= delay_reg[i];
            end
        end

        // Command reset restores working settings only; auto sync and time offset are kept.
        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i | rst_all) begin
                freq_reg[i] <= FDEF;
                func_reg[i] <= 3'h0;
                pview_reg[i] <= 1'b0;
                unit_reg[i] <= unit_deg;
                phase_reg[i] <= 32'h0000_0000;
                ref_reg[i] <= 32'h0000_0000;
            end else begin
                if (sel & (cmd_reg.op == op_set_freq)) begin
                    freq_reg[i] <= fset_w;
                end
                if (sel & (cmd_reg.op == op_set_func)) begin
                    func_reg[i] <= fn_new;
                end
                if (sel & (cmd_reg.op == op_set_pview)) begin
                    pview_reg[i] <= data_reg[0];
                end
                if (sel & (cmd_reg.op == op_set_unit)) begin
                    unit_reg[i] <= cmd_reg.unit;
                end
                if (sel & (cmd_reg.op == op_set_phase)) begin
                    phase_reg[i] <= ph_wrap[31:0];
                end
                if (sel & (cmd_reg.op == op_phase_ref)) begin
                    ref_reg[i] <= out_wrap[31:0];
                    phase_reg[i] <= 32'h0000_0000;
                end
                if (op_sync_w) begin
                    ref_reg[i] <= 32'h0000_0000;
                    phase_reg[i] <= 32'h0000_0000;
                end
            end
        end

        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                src_o[i] <= '0;
                src_o[i].enable <= 1'b1;
                src_o[i].freq_mhz <= FDEF;
            end else begin
                if (go_sync) begin
                    src_o[i].enable <= 1'b0;
                end else if (align_now) begin
                    src_o[i].enable <= 1'b1;
                end
                src_o[i].align <= align_now;
                src_o[i].func <= func_reg[i];
                src_o[i].pview <= pview_reg[i];
                src_o[i].freq_mhz <= freq_reg[i];
                src_o[i].phase_mdeg <= out_wrap[31:0];
                src_o[i].delay_ns <= delay_reg[i];
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/sopc_props.sv]
`include "sopc_map.svh"
`default_nettype none
module sopc_props
    import sopc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic nvm_wr_o,
    input wire sopc_src_t src_o [3]
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("ready late");
    chk_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready stuck");
    chk_unmapped_err: assert property (pready_o && paddr_i > 12'h014 |-> pslverr_o)
        else $error("no slave error");
    chk_idle_rdata: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data leaks");
    chk_phase_mod: assert property (src_o[0].phase_mdeg < `SOPC_FULL_TURN)
        else $error("phase not wrapped");
    chk_sine_range: assert property (src_o[0].freq_mhz >= `SOPC_FMIN &&
        src_o[0].freq_mhz <= `SOPC_FMAX_SINE) else $error("sine freq range");
    chk_pulse_range: assert property (src_o[2].freq_mhz <= `SOPC_FMAX_PULSE)
        else $error("pulse freq range");
    chk_delay_span: assert property ($signed(src_o[0].delay_ns) <=
        $signed(`SOPC_DELAY_MAX) && $signed(src_o[0].delay_ns) >= -$signed(`SOPC_DELAY_MAX))
        else $error("delay range");
    chk_align_once: assert property (src_o[0].align |-> src_o[0].enable ##1
        !src_o[0].align) else $error("align pulse");
    chk_nvm_pulse: assert property (nvm_wr_o |=> !nvm_wr_o)
        else $error("store pulse");
endmodule
bind sopc_top sopc_props chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .nvm_wr_o(nvm_wr_o), .src_o(src_o));
`default_nettype wire

// [testbench/sopc_far_model.sv]
`default_nettype none
module sopc_far_model #(
    parameter int PPS_NS = 1337
) (
    input wire logic ref_clk_i,
    input wire logic utc_known_i,
    input wire logic nvm_wr_i,
    input wire logic [2:0] nvm_auto_i,
    input wire logic [31:0] nvm_delay_i [3],
    output logic utc_pps_o,
    output logic utc_valid_o,
    output logic [2:0] nvm_auto_o,
    output logic [31:0] nvm_delay_o [3]
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pulse output auto-syncs from power on.
    initial begin
        nvm_auto_o = 3'b100;
        nvm_delay_o = '{32'h0, 32'h0000_0064, 32'h0};
    end
    assign utc_valid_o = utc_known_i;
    // The second mark is not a clock multiple, so it drifts against the core clock.
    always begin
        utc_pps_o = 1'b0;
        #(PPS_NS);
        utc_pps_o = utc_known_i;
        #(50);
    end
    always @(posedge ref_clk_i) begin
        if (nvm_wr_i) begin
            nvm_auto_o <= nvm_auto_i;
            nvm_delay_o <= nvm_delay_i;
        end
    end
endmodule
`default_nettype wire

// [testbench/sopc_top_test.sv]
`include "sopc_map.svh"
`default_nettype none
module sopc_top_test
    import sopc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0, prd;
    logic rdy, serr, pps, uval, nwr, cerr, known = 1'b1;
    logic [2:0] au_in, au_out;
    logic [31:0] dl_in [3], dl_out [3];
    logic [39:0] res;
    sopc_src_t src [3];
    int err_count = 0, total_checks = 0;
    always #5 clk = ~clk;
    sopc_top #(.CYC_PER_SEC(200)) uut (.ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(rdy), .pslverr_o(serr), .utc_pps_i(pps), .utc_valid_i(uval),
        .nvm_auto_i(au_in), .nvm_delay_i(dl_in), .nvm_wr_o(nwr), .nvm_auto_o(au_out),
        .nvm_delay_o(dl_out), .src_o(src));
    sopc_far_model far (.ref_clk_i(clk), .nvm_wr_i(nwr), .nvm_auto_i(au_out),
        .nvm_delay_i(dl_out), .utc_pps_o(pps), .utc_valid_o(uval), .nvm_auto_o(au_in),
        .nvm_delay_o(dl_in), .utc_known_i(known));
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [39:0] exp, input logic [39:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        q = prd;
        e = serr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (rdy !== 1'b1) begin
            err_count++;
            results();
        end
    endtask
    task automatic cmd(input sopc_op_t op, input logic [1:0] sfx, input sopc_unit_t u,
        input sopc_lim_t l, input logic [39:0] v);
        logic [31:0] q;
        logic e;
        sopc_cmd_t c;
        c = '{l, u, sfx, op};
        apb(1'b1, `SOPC_OFF_DATA_LO, v[31:0], q, e);
        apb(1'b1, `SOPC_OFF_DATA_HI, {24'h0, v[39:32]}, q, e);
        apb(1'b1, `SOPC_OFF_CMD, {22'h0, c}, q, e);
        repeat (60) begin
            apb(1'b0, `SOPC_OFF_STATUS, 32'h0, q, e);
            if (q[`SOPC_ST_BUSY] === 1'b0) break;
        end
        chk("busy", 40'h0, {39'h0, q[`SOPC_ST_BUSY]});
        cerr = q[`SOPC_ST_ERR];
        apb(1'b0, `SOPC_OFF_RES_LO, 32'h0, q, e);
        res[31:0] = q;
        apb(1'b0, `SOPC_OFF_RES_HI, 32'h0, q, e);
        res[39:32] = q[7:0];
    endtask
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        chk("auto restore", 40'h4, {37'h0, au_out});
        chk("delay restore", 40'h64, {8'h0, dl_out[1]});
        apb(1'b0, 12'h018, 32'h0, q, e);
        chk("unmapped", 40'h1_0000_0000, {7'h0, e, q});
        $display("test reset done");
    endtask
    task automatic t_freq();
        cmd(op_set_freq, 2'h0, unit_deg, lim_value, {4'h0, `SOPC_FMAX_SINE});
        chk("sine max", {4'h0, `SOPC_FMAX_SINE}, {4'h0, src[0].freq_mhz});
        chk("seamless", 40'h1, {39'h0, src[0].enable});
        cmd(op_set_freq, 2'h1, unit_deg, lim_value, {4'h0, `SOPC_FMAX_SINE} + 40'h1);
        chk("too high", 40'h1, {39'h0, cerr});
        chk("kept", {4'h0, `SOPC_FMAX_SINE}, {4'h0, src[0].freq_mhz});
        cmd(op_get_freq, 2'h1, unit_deg, lim_max, 40'h0);
        chk("max query", {4'h0, `SOPC_FMAX_SINE}, res);
        cmd(op_get_freq, 2'h2, unit_deg, lim_min, 40'h0);
        chk("min query", 40'h1, res);
        cmd(op_set_freq, 2'h3, unit_deg, lim_value, {4'h0, `SOPC_FMAX_PULSE} + 40'h1);
        chk("pulse high", 40'h1, {39'h0, cerr});
        $display("test freq done");
    endtask
    task automatic t_func();
        cmd(op_set_freq, 2'h2, unit_deg, lim_value, {4'h0, `SOPC_FMAX_AUX_SIN});
        chk("aux sin max", 40'h0, {39'h0, cerr});
        cmd(op_set_func, 2'h2, unit_deg, lim_value, 40'h1);
        chk("tri refused", 40'h1, {39'h0, cerr});
        cmd(op_set_freq, 2'h2, unit_deg, lim_value, {4'h0, `SOPC_FMAX_AUX});
        for (int i = 0; i < 5; i++) begin
            cmd(op_set_func, 2'h2, unit_deg, lim_value, 40'(i));
            cmd(op_get_cfg, 2'h2, unit_deg, lim_value, 40'h0);
            chk("aux func", 40'(i), {37'h0, res[2:0]});
        end
        cmd(op_set_func, 2'h1, unit_deg, lim_value, 40'h1);
        chk("sine func", 40'h1, {39'h0, cerr});
        cmd(op_set_func, 2'h3, unit_deg, lim_value, 40'h1);
        cmd(op_get_cfg, 2'h3, unit_deg, lim_value, 40'h0);
        chk("pulse func", 40'h1, {37'h0, res[2:0]});
        cmd(op_set_pview, 2'h3, unit_deg, lim_value, 40'h1);
        chk("view irig", 40'h1, {39'h0, cerr});
        cmd(op_set_func, 2'h3, unit_deg, lim_value, 40'h0);
        cmd(op_set_pview, 2'h3, unit_deg, lim_value, 40'h1);
        chk("view plain", 40'h1, {39'h0, src[2].pview});
        $display("test func done");
    endtask
    task automatic t_phase();
        cmd(op_set_phase, 2'h1, unit_deg, lim_value, 40'h5_5730);
        cmd(op_set_phase, 2'h1, unit_deg, lim_value, 40'h5_A550);
        chk("wrap", 40'h2710, {8'h0, src[0].phase_mdeg});
        cmd(op_set_phase, 2'h1, unit_deg, lim_value, 40'h5_A551);
        chk("over turn", 40'h1, {39'h0, cerr});
        cmd(op_set_phase, 2'h1, unit_deg, lim_value, 40'hFF_FFFF_EC78);
        chk("lag", 40'h5_6AB8, {8'h0, src[0].phase_mdeg});
        cmd(op_phase_ref, 2'h1, unit_deg, lim_value, 40'h0);
        chk("ref out", 40'h5_6AB8, {8'h0, src[0].phase_mdeg});
        cmd(op_get_phase, 2'h1, unit_default, lim_value, 40'h0);
        chk("ref zero", 40'h0, res);
        cmd(op_set_phase, 2'h1, unit_deg, lim_value, 40'h1_5F90);
        cmd(op_get_phase, 2'h1, unit_sec, lim_value, 40'h0);
        chk("phase ns", 40'h8, res);
        cmd(op_set_unit, 2'h1, unit_default, lim_value, 40'h0);
        chk("bad unit", 40'h1, {39'h0, cerr});
        $display("test phase done");
    endtask
    task automatic t_sync(input int k, input sopc_op_t op, input logic [1:0] sfx);
        logic off = 1'b0;
        int n = 0;
        // Start at a UTC second mark, well before the next one, or after 200 cycles when no mark comes.
        for (int m = 0; m < 200 && pps !== 1'b1; m++) @(posedge clk);
        cmd(op, sfx, unit_deg, lim_value, 40'h7D0);
        while (src[k].align !== 1'b1 && n < 600) begin
            off |= !src[k].enable;
            @(posedge clk);
            n++;
        end
        chk("realign", 40'h7, {37'h0, off, src[k].align, src[k].enable});
        $display("test sync done");
    endtask
    task automatic t_delay();
        cmd(op_set_delay, 2'h1, unit_deg, lim_value, 40'hFF_C465_3600);
        chk("delay min", 40'hC465_3600, {8'h0, dl_out[0]});
        cmd(op_set_delay, 2'h1, unit_deg, lim_value, 40'hFF_C465_35FF);
        chk("delay low", 40'h1, {39'h0, cerr});
        cmd(op_set_auto, 2'h2, unit_deg, lim_value, 40'h1);
        cmd(op_cmd_reset, 2'h1, unit_deg, lim_value, 40'h0);
        chk("delay kept", 40'hC465_3600, {8'h0, dl_out[0]});
        chk("auto kept", 40'h6, {37'h0, au_out});
        chk("auto stored", 40'h6, {37'h0, au_in});
        chk("freq reset", {4'h0, `SOPC_FDEF_BASE}, {4'h0, src[0].freq_mhz});
        $display("test delay done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_freq();
        t_func();
        t_phase();
        t_sync(0, op_sync, 2'h1);
        t_sync(2, op_set_freq, 2'h3);
        known <= 1'b0;
        t_sync(1, op_sync, 2'h2);
        t_delay();
        results();
    end
endmodule
`default_nettype wire
